// *** hw/cpsc_top.sv ***
/*
 * Clock prescale and sleep control: oscillator trim register, protected
 * power-of-two system clock prescaler, sleep mode clock gating and wake-up
 * sequencing, reached over an AHB-Lite slave port.
 * Assumes hclk is the undivided master clock and keeps running in this
 * model; the clock-run outputs are requests to the clock tree. The core
 * pulses sleep_instr for one cycle when it executes the sleep instruction,
 * and the interrupt inputs are already qualified by their enables.
 */
`timescale 1ns/1ns

module cpsc_top #(
	parameter int unsigned PD_WAKE_CYCLES = 16 // power-down start-up cycles
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [7:0] factory_trim,
	input wire logic boot_divide_by_eight_fuse,
	input wire logic xtal_clock_selected,
	input wire logic sleep_instr,
	input wire logic adc_enable,
	input wire logic ext_irq_edge,
	input wire logic ext_irq_zero_level,
	input wire logic pin_change_irq,
	input wire logic periph_irq,
	input wire logic adc_done_irq,
	input wire logic mem_ready_irq,
	output logic [7:0] osc_trim,
	output logic sys_tick,
	output logic core_clk_run,
	output logic flash_clk_run,
	output logic io_clk_run,
	output logic adc_clk_run,
	output logic osc_run,
	output logic core_halt,
	output logic adc_start_conv,
	output cpsc_pkg::cpsc_state_t sleep_state
);
	import cpsc_pkg::*;

	logic ap_take; // address phase accepted this cycle
	logic dp_wr; // write data phase in progress
	logic dp_rd; // read data phase in progress
	logic dp_map; // address was aligned and inside the map
	logic [7:0] dp_idx; // register index of the data phase
	logic wr_pres; // write to the prescale register
	logic set_req; // unlock request with other bits zero
	logic wr_code; // divide code write inside the window
	logic unlock; // divide_change_unlock
	logic [2:0] unlock_cnt; // cycles left in the unlock window
	logic boot_done; // trim and divide code captured after reset
	logic [3:0] code; // clock_divide_code
	logic [3:0] active_shift; // shift of the period now running
	logic [3:0] next_shift; // shift for the next period
	logic [7:0] div_cnt; // prescaler count within a period
	logic [7:0] div_lim; // last count of the current period
	logic sleep_arm; // sleep_arm
	logic [1:0] sleep_mode; // sleep_mode_select
	logic [1:0] mode_q; // mode captured at sleep entry
	logic standby_q; // standby taken at sleep entry
	logic [15:0] wake_cnt; // start-up or halt cycles left
	logic wake_hit; // a wake source for the current mode
	logic go_sleep; // sleep instruction taken
	cpsc_state_t next_state; // sequencer next state
	logic [31:0] rd_mux; // read data selected by index

	assign ap_take = hsel && hready && htrans[1];
	assign wr_pres = dp_wr && dp_map && dp_idx == IDX_PRESCALE;
	assign set_req = wr_pres && hwdata[PRE_UNLOCK_BIT] && hwdata[6:0] == 7'h00;
	assign wr_code = wr_pres && !hwdata[PRE_UNLOCK_BIT] && unlock;
	assign go_sleep = sleep_state == ST_ACTIVE && sleep_instr && sleep_arm;

	// bus slave: capture the address phase, reads take one wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr <= 1'b0;
			dp_rd <= 1'b0;
			dp_map <= 1'b0;
			dp_idx <= 8'h00;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			dp_wr <= ap_take && hwrite;
			dp_rd <= ap_take && !hwrite;
			hreadyout <= !(ap_take && !hwrite);
			hresp <= 1'b0;
			if (ap_take) begin
				dp_map <= haddr[31:10] == 22'h0 && haddr[1:0] == 2'h0;
				dp_idx <= haddr[9:2];
			end
		end
	end

	// read data mux; unmapped addresses and unused bits read zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (dp_map) begin
			unique case (dp_idx)
				IDX_PRESCALE: begin
					rd_mux[PRE_UNLOCK_BIT] = unlock; // bits 6:4 stay zero
					rd_mux[PRE_CODE_LSB +: PRE_CODE_W] = code;
				end
				IDX_TRIM: rd_mux[7:0] = osc_trim;
				IDX_CORE_CTRL: begin
					rd_mux[CTL_ARM_BIT] = sleep_arm;
					rd_mux[CTL_MODE_LSB +: 2] = sleep_mode;
				end
				IDX_STATUS: begin
					rd_mux[STA_STATE_LSB +: 4] = sleep_state;
					rd_mux[STA_UNLOCK_BIT] = unlock;
					rd_mux[STA_MODE_LSB +: 2] = mode_q;
					rd_mux[STA_STANDBY_BIT] = standby_q;
				end
				default: rd_mux = 32'h0000_0000;
			endcase
		end
	end

	// read data register, loaded in the wait cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= RDATA_RESET;
		end else if (dp_rd) begin
			hrdata <= rd_mux;
		end
	end

	// boot capture and trim register; osc_trim[7] is the range bit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			boot_done <= 1'b0;
			osc_trim <= TRIM_RESET;
		end else if (!boot_done) begin
			boot_done <= 1'b1;
			osc_trim <= factory_trim;
		end else if (dp_wr && dp_map && dp_idx == IDX_TRIM) begin
			osc_trim <= hwdata[7:0];
		end
	end

	// unlock window: set only from closed, never restarted, four cycles long
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			unlock <= 1'b0;
			unlock_cnt <= 3'h0;
		end else if (unlock) begin
			if (wr_code || unlock_cnt == 3'h1) begin
				unlock <= 1'b0;
				unlock_cnt <= 3'h0;
			end else begin
				unlock_cnt <= unlock_cnt - 3'h1; // a second request is ignored
			end
		end else if (set_req) begin
			unlock <= 1'b1;
			unlock_cnt <= UNLOCK_CYCLES;
		end
	end

	// divide code: fuse value at boot, then any code through the window
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			code <= CODE_RESET;
		end else if (!boot_done) begin
			code <= boot_divide_by_eight_fuse ? CODE_DIV8 : CODE_DIV1;
		end else if (wr_code) begin
			code <= hwdata[PRE_CODE_LSB +: PRE_CODE_W];
		end
	end

	// period limit; reserved codes divide by the largest factor
	always_comb begin
		next_shift = code > CODE_MAX ? CODE_MAX : code;
		div_lim = 8'((9'h001 << active_shift) - 9'h001);
	end

	// prescaler: a new code takes effect only when a period completes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_cnt <= 8'h00;
			active_shift <= CODE_RESET;
			sys_tick <= 1'b0;
		end else if (div_cnt >= div_lim) begin
			div_cnt <= 8'h00;
			active_shift <= next_shift;
			sys_tick <= 1'b1;
		end else begin
			div_cnt <= div_cnt + 8'h01;
			sys_tick <= 1'b0;
		end
	end

	// core control bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sleep_arm <= 1'b0;
			sleep_mode <= MODE_IDLE;
		end else if (dp_wr && dp_map && dp_idx == IDX_CORE_CTRL) begin
			sleep_arm <= hwdata[CTL_ARM_BIT];
			sleep_mode <= hwdata[CTL_MODE_LSB +: 2];
		end
	end

	// wake sources allowed in each mode
	always_comb begin
		unique case (mode_q)
			MODE_IDLE: wake_hit = ext_irq_edge || ext_irq_zero_level || pin_change_irq
				|| periph_irq || adc_done_irq || mem_ready_irq;
			MODE_NOISE: wake_hit = adc_done_irq || mem_ready_irq || ext_irq_zero_level
				|| pin_change_irq;
			MODE_PDOWN, MODE_STANDBY: wake_hit = ext_irq_zero_level || pin_change_irq;
		endcase
	end

	// sequencer next state
	always_comb begin
		next_state = sleep_state;
		unique case (sleep_state)
			ST_ACTIVE: if (go_sleep) begin
				next_state = ST_SLEEP;
			end
			ST_SLEEP: if (wake_hit) begin
				next_state = mode_q[1] ? ST_START : ST_HALT;
			end
			ST_START: if (wake_cnt == 16'h0001) begin
				next_state = ST_HALT;
			end
			ST_HALT: if (wake_cnt == 16'h0001) begin
				next_state = ST_ACTIVE;
			end
		endcase
	end

	// sequencer state, captured mode and cycle counter; reset always wakes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sleep_state <= ST_ACTIVE;
			mode_q <= MODE_IDLE;
			standby_q <= 1'b0;
			wake_cnt <= 16'h0000;
		end else begin
			sleep_state <= next_state;
			if (go_sleep) begin
				mode_q <= sleep_mode;
				standby_q <= sleep_mode == MODE_STANDBY && xtal_clock_selected;
			end
			if (sleep_state == ST_SLEEP && wake_hit) begin
				if (!mode_q[1]) begin
					wake_cnt <= WAKE_HALT_CYCLES;
				end else if (standby_q) begin
					wake_cnt <= STANDBY_WAKE_CYCLES;
				end else begin
					wake_cnt <= 16'(PD_WAKE_CYCLES);
				end
			end else if (sleep_state == ST_START && wake_cnt == 16'h0001) begin
				wake_cnt <= WAKE_HALT_CYCLES;
			end else if (wake_cnt != 16'h0000) begin
				wake_cnt <= wake_cnt - 16'h0001;
			end
		end
	end

	// clock-run requests and core halt, registered from the next state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			core_clk_run <= 1'b1;
			flash_clk_run <= 1'b1;
			io_clk_run <= 1'b1;
			adc_clk_run <= 1'b1;
			osc_run <= 1'b1;
			core_halt <= 1'b0;
		end else begin
			core_clk_run <= next_state == ST_ACTIVE;
			flash_clk_run <= next_state == ST_ACTIVE || next_state == ST_HALT;
			core_halt <= next_state != ST_ACTIVE;
			if (next_state == ST_SLEEP) begin
				// idle keeps I/O and converter; noise keeps the converter
				io_clk_run <= (go_sleep ? sleep_mode : mode_q) == MODE_IDLE;
				adc_clk_run <= !(go_sleep ? sleep_mode[1] : mode_q[1]);
				osc_run <= go_sleep ? (sleep_mode != MODE_PDOWN
					&& !(sleep_mode == MODE_STANDBY && !xtal_clock_selected))
					: (!mode_q[1] || standby_q);
			end else if (next_state == ST_START) begin
				io_clk_run <= 1'b0;
				adc_clk_run <= 1'b0;
				osc_run <= 1'b1;
			end else begin
				io_clk_run <= 1'b1;
				adc_clk_run <= 1'b1;
				osc_run <= 1'b1;
			end
		end
	end

	// one-cycle conversion start when entering idle or noise reduction
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			adc_start_conv <= 1'b0;
		end else begin
			adc_start_conv <= go_sleep && adc_enable && !sleep_mode[1];
		end
	end

	// helper for the tick spacing check
	logic [9:0] since_tick; // cycles since the previous tick
	logic seen_tick; // at least one tick since reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			since_tick <= 10'h000;
			seen_tick <= 1'b0;
		end else begin
			since_tick <= sys_tick ? 10'h001 : since_tick + 10'h001;
			seen_tick <= seen_tick || sys_tick;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence unlock_open_s;
		$rose(unlock);
	endsequence

	sequence halt_four_s;
		(sleep_state == ST_HALT && core_halt && !core_clk_run)[*4] ##1 sleep_state == ST_ACTIVE;
	endsequence

	sequence standby_start_s;
		(sleep_state == ST_START && osc_run)[*6] ##1 sleep_state == ST_HALT;
	endsequence

	boot_load_a: assert property ($rose(boot_done) |=> osc_trim == $past(factory_trim, 2)
		&& code == ($past(boot_divide_by_eight_fuse, 2) ? CODE_DIV8 : CODE_DIV1))
		else $error("trim or divide code not loaded at boot");
	unlock_set_a: assert property (!unlock && wr_pres && hwdata[6:0] != 7'h00 |=> !unlock)
		else $error("unlock set with other bits nonzero");
	unlock_hold_a: assert property (unlock_open_s ##0 (!wr_code)[*3] |=> unlock)
		else $error("unlock window closed early");
	unlock_close_a: assert property (unlock_open_s ##0 (!wr_code)[*4] |=> !unlock)
		else $error("unlock window not closed after four cycles");
	no_restart_a: assert property (unlock && set_req && unlock_cnt != 3'h1
		|=> unlock && unlock_cnt == $past(unlock_cnt) - 3'h1)
		else $error("second unlock disturbed the window");
	code_write_a: assert property (wr_code |=> !unlock && code == $past(hwdata[3:0]))
		else $error("divide code not taken in window");
	code_locked_a: assert property (boot_done && wr_pres && !unlock |=> $stable(code))
		else $error("divide code changed without unlock");
	reserved_zero_a: assert property (dp_rd && dp_map && dp_idx == IDX_PRESCALE
		|=> hrdata[6:4] == 3'h0 && hreadyout)
		else $error("reserved prescale bits read nonzero");
	tick_spacing_a: assert property (sys_tick && seen_tick && $past(seen_tick)
		|-> since_tick == (10'h001 << $past(active_shift)))
		else $error("prescaler period wrong");
	sleep_ignore_a: assert property (sleep_state == ST_ACTIVE && sleep_instr && !sleep_arm
		|=> sleep_state == ST_ACTIVE && core_clk_run)
		else $error("unarmed sleep had an effect");
	idle_clocks_a: assert property (sleep_state == ST_SLEEP && mode_q == MODE_IDLE
		|-> !core_clk_run && !flash_clk_run && io_clk_run && adc_clk_run)
		else $error("idle clock gating wrong");
	noise_clocks_a: assert property (sleep_state == ST_SLEEP && mode_q == MODE_NOISE
		|-> !io_clk_run && !core_clk_run && adc_clk_run)
		else $error("noise reduction clock gating wrong");
	pdown_clocks_a: assert property (sleep_state == ST_SLEEP && mode_q == MODE_PDOWN
		|-> !osc_run && !io_clk_run && !adc_clk_run)
		else $error("power-down left a clock running");
	idle_wake_a: assert property (sleep_state == ST_SLEEP && mode_q == MODE_IDLE && periph_irq
		|=> halt_four_s)
		else $error("idle wake sequence wrong");
	noise_wake_a: assert property (sleep_state == ST_SLEEP && mode_q == MODE_NOISE && !wake_hit
		|=> sleep_state == ST_SLEEP)
		else $error("noise reduction woke on a blocked source");
	standby_wake_a: assert property (sleep_state == ST_SLEEP && standby_q && wake_hit
		|=> standby_start_s ##0 halt_four_s)
		else $error("standby wake timing wrong");
	adc_start_a: assert property (go_sleep && adc_enable && !sleep_mode[1]
		|=> adc_start_conv ##1 !adc_start_conv)
		else $error("conversion start missing on sleep entry");
	arm_needed_a: assert property (sleep_state == ST_ACTIVE && !go_sleep
		|=> sleep_state == ST_ACTIVE)
		else $error("sleep entered without arm and instruction");

endmodule

// *** hw/cpsc_pkg.sv ***
/*
 * Package for the clock prescale and sleep control block: register indices,
 * field positions, reset values, cycle counts and the sleep state encoding.
 * Assumes a 32-bit AHB-Lite register bus, in which each register index maps
 * to the byte address four times the index.
 */
package cpsc_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_PRESCALE = 8'h26; // clock_prescale_register
	localparam logic [7:0] IDX_TRIM = 8'h31; // oscillator_trim_register
	localparam logic [7:0] IDX_CORE_CTRL = 8'h35; // core_control_register
	localparam logic [7:0] IDX_STATUS = 8'h3F; // sleep and unlock status

	// clock_prescale_register fields
	localparam int unsigned PRE_UNLOCK_BIT = 7; // divide_change_unlock
	localparam int unsigned PRE_CODE_LSB = 0; // clock_divide_code low bit
	localparam int unsigned PRE_CODE_W = 4; // clock_divide_code width

	// core_control_register fields
	localparam int unsigned CTL_ARM_BIT = 5; // sleep_arm
	localparam int unsigned CTL_MODE_LSB = 3; // sleep_mode_select low bit

	// status register fields
	localparam int unsigned STA_STATE_LSB = 0; // one-hot sleep state, 4 bits
	localparam int unsigned STA_UNLOCK_BIT = 4; // unlock window open
	localparam int unsigned STA_MODE_LSB = 5; // mode captured at sleep entry
	localparam int unsigned STA_STANDBY_BIT = 7; // standby taken

	// reset values
	localparam logic [7:0] TRIM_RESET = 8'h00; // until the factory value loads
	localparam logic [3:0] CODE_RESET = 4'h0; // until the fuse is sampled
	localparam logic [3:0] CODE_DIV1 = 4'h0; // fuse unprogrammed
	localparam logic [3:0] CODE_DIV8 = 4'h3; // fuse programmed
	localparam logic [3:0] CODE_MAX = 4'h8; // divide by 256, higher reserved
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

	// cycle counts
	localparam logic [2:0] UNLOCK_CYCLES = 3'h4; // unlock window length
	localparam logic [15:0] WAKE_HALT_CYCLES = 16'h0004; // core held after start-up
	localparam logic [15:0] STANDBY_WAKE_CYCLES = 16'h0006; // standby start-up

	// sleep mode select encodings
	localparam logic [1:0] MODE_IDLE = 2'h0;
	localparam logic [1:0] MODE_NOISE = 2'h1;
	localparam logic [1:0] MODE_PDOWN = 2'h2;
	localparam logic [1:0] MODE_STANDBY = 2'h3;

	// sleep sequencer states
	typedef enum logic [3:0] {
		ST_ACTIVE = 4'h1, // core running
		ST_SLEEP = 4'h2, // clocks stopped, waiting for a wake source
		ST_START = 4'h4, // oscillator start-up after deep sleep
		ST_HALT = 4'h8 // clocks back, core still held
	} cpsc_state_t;

endpackage

// *** verification/cpsc_core_model.sv ***
/* core model for the clock prescale and sleep block: sleep instruction and interrupt requests.
 * assumes its tasks are called just after a rising edge of hclk. */
`timescale 1ns/1ns
module cpsc_core_model (
	input wire logic hclk,
	input wire logic core_halt,
	output logic sleep_instr,
	output logic ext_irq_edge,
	output logic ext_irq_zero_level,
	output logic pin_change_irq,
	output logic periph_irq,
	output logic adc_done_irq,
	output logic mem_ready_irq
);
	logic was_halted; // core_halt one edge back
	// nothing pending and no sleep at start
	initial begin
		sleep_instr = 1'b0;
		was_halted = 1'b0;
		raise(6'h00);
	end
	// a held core executes nothing, so the sleep instruction waits until it runs
	task automatic sleep_op();
		while (core_halt === 1'b1) @(posedge hclk);
		sleep_instr <= 1'b1;
		@(posedge hclk);
		sleep_instr <= 1'b0;
	endtask
	// request lines: edge, level, pin change, peripheral, conversion, memory
	task automatic raise(input logic [5:0] v);
		{ext_irq_edge, ext_irq_zero_level, pin_change_irq,
			periph_irq, adc_done_irq, mem_ready_irq} <= v;
	endtask
	// once released the core runs its interrupt routine, which acknowledges every request
	always @(posedge hclk) begin
		was_halted <= core_halt;
		if (was_halted && !core_halt) begin
			raise(6'h00);
		end
	end
endmodule

// *** verification/testbench.sv ***
/* self-checking bench for the clock prescale and sleep block: AHB-Lite register tasks,
 * divider unlock and timing, sleep entry, gating and wake-up, reset while asleep.
 * assumes cpsc_core_model as the core and hclk at 50 ns. */
`timescale 1ns/1ns
module testbench;
	import cpsc_pkg::*;
	localparam int PDW = 3; // short power-down start-up for simulation
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [7:0] ftrim = 8'h6A; // factory trim value
	logic fuse = 1'b1; // boot divide-by-eight fuse programmed
	logic xtal = 1'b0; // crystal clock not selected
	logic adc_en = 1'b1; // converter enabled
	logic [31:0] hrdata;
	logic [7:0] osc_trim;
	logic hreadyout, sys_tick, core_halt, conv, slp, e_edge, e_lvl, pin, per, adcd, memr;
	logic core_run, flash_run, io_run, adc_run, osc_run;
	cpsc_state_t st;
	wire logic [5:0] gates = {core_halt, core_run, flash_run, io_run, adc_run, osc_run};
	int miscompares = 0;
	int tests_run = 0;
	int cyc = 0; // cycles run, for the hang limit
	int n_start = 0, n_halt = 0, n_conv = 0;
	// sleep cases: mode, crystal, gates asleep, non-waking and waking requests
	logic [1:0] md [6] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
	logic xt [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
	logic [5:0] gt [6] = '{6'h27, 6'h27, 6'h23, 6'h20, 6'h21, 6'h20};
	logic [5:0] nw [6] = '{6'h00, 6'h00, 6'h24, 6'h27, 6'h27, 6'h27};
	logic [5:0] wk [6] = '{6'h04, 6'h20, 6'h02, 6'h08, 6'h10, 6'h08};
	int sw [6] = '{0, 0, 0, PDW, 6, PDW}; // start-up cycles
	int cv [6] = '{1, 0, 1, 0, 0, 0}; // conversions started; case 1 has the converter off
	logic [7:0] cd [5] = '{8'h03, 8'h00, 8'h08, 8'h01, 8'h09}; // divide codes
	cpsc_top #(.PD_WAKE_CYCLES(PDW)) dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(), .factory_trim(ftrim), .boot_divide_by_eight_fuse(fuse),
		.xtal_clock_selected(xtal), .sleep_instr(slp), .adc_enable(adc_en), .ext_irq_edge(e_edge),
		.ext_irq_zero_level(e_lvl), .pin_change_irq(pin), .periph_irq(per),
		.adc_done_irq(adcd), .mem_ready_irq(memr), .osc_trim(osc_trim), .sys_tick(sys_tick),
		.core_clk_run(core_run), .flash_clk_run(flash_run), .io_clk_run(io_run),
		.adc_clk_run(adc_run), .osc_run(osc_run), .core_halt(core_halt),
		.adc_start_conv(conv), .sleep_state(st)
	);
	cpsc_core_model core (
		.hclk(hclk), .core_halt(core_halt), .sleep_instr(slp), .ext_irq_edge(e_edge),
		.ext_irq_zero_level(e_lvl), .pin_change_irq(pin), .periph_irq(per),
		.adc_done_irq(adcd), .mem_ready_irq(memr)
	);
	// master clock
	initial begin
		forever #25 hclk = ~hclk;
	end
	// hang limit and tallies of start-up, halt and conversion cycles
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (st === ST_START) n_start <= n_start + 1;
		if (st === ST_HALT) n_halt <= n_halt + 1;
		if (conv === 1'b1) n_conv <= n_conv + 1;
		if (cyc == 20000) begin
			miscompares++;
			wrap_up();
		end
	end
	// address phase until taken, then the data phase until hready
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		haddr <= {22'h0, idx, 2'h0};
		hwrite <= 1'b1;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask
	// read a register; data taken at the edge that ends the data phase
	task automatic rchk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
		haddr <= {22'h0, idx, 2'h0};
		hwrite <= 1'b0;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		chk(nm, exp, hrdata);
	endtask
	// compare one value and count it
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// unlock writes, trim fillers, then the code; no request is raised meanwhile
	task automatic change(input int nu, input int nt, input logic [7:0] code);
		repeat (nu) wr(IDX_PRESCALE, 8'h80);
		repeat (nt) wr(IDX_TRIM, 8'h7F);
		wr(IDX_PRESCALE, code);
	endtask
	// cycles from one divided clock tick to the next
	task automatic period(output int n);
		do @(posedge hclk); while (sys_tick !== 1'b1);
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (sys_tick !== 1'b1);
	endtask
	// counts, verdict and end of run
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		int p1, p2, old, e;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rchk("trim", IDX_TRIM, 32'h6A);
		rchk("prescale", IDX_PRESCALE, 32'h03);
		rchk("status", IDX_STATUS, 32'h01);
		wr(8'h10, 8'hFF);
		rchk("unmapped", 8'h10, 32'h0);
		wr(IDX_TRIM, 8'h80);
		@(posedge hclk);
		chk("range", 32'h80, {24'h0, osc_trim});
		wr(IDX_TRIM, 8'h7F);
		@(posedge hclk);
		chk("tune", 32'h7F, {24'h0, osc_trim});
		wr(IDX_PRESCALE, 8'h81);
		wr(IDX_PRESCALE, 8'h05);
		rchk("no unlock", IDX_PRESCALE, 32'h03);
		change(1, 1, 8'h05);
		rchk("code in window", IDX_PRESCALE, 32'h05);
		change(1, 4, 8'h01);
		rchk("late code", IDX_PRESCALE, 32'h05);
		change(2, 1, 8'h01);
		rchk("relock", IDX_PRESCALE, 32'h05);
		wr(IDX_PRESCALE, 8'h80);
		rchk("window open", IDX_PRESCALE, 32'h85);
		rchk("window shut", IDX_PRESCALE, 32'h05);
		change(1, 0, 8'h7F);
		rchk("reserved", IDX_PRESCALE, 32'h0F);
		old = 256;
		foreach (cd[i]) begin
			change(1, 0, cd[i]);
			e = 1 << ((cd[i] > 8) ? 8 : cd[i]);
			period(p1);
			period(p2);
			chk("switch period", 32'h1, 32'(p1 >= ((e < old) ? e : old)));
			chk("period", e, p2);
			old = e;
		end
		wr(IDX_CORE_CTRL, 8'h00);
		core.sleep_op();
		repeat (2) @(posedge hclk);
		chk("unarmed", 32'h1F, {26'h0, gates});
		for (int i = 0; i < 6; i++) begin
			xtal <= xt[i];
			adc_en <= (cv[i] != 0) || md[i][1];
			n_start <= 0;
			n_halt <= 0;
			n_conv <= 0;
			wr(IDX_CORE_CTRL, {2'h0, 1'b1, md[i], 3'h0});
			core.sleep_op();
			@(posedge hclk);
			chk("gating", gt[i], {26'h0, gates});
			core.raise(nw[i]);
			repeat (4) @(posedge hclk);
			chk("asleep", ST_SLEEP, {28'h0, st});
			core.raise(nw[i] | wk[i]);
			do @(posedge hclk); while (st !== ST_ACTIVE);
			chk("start", sw[i], n_start);
			chk("halt", 32'h4, n_halt);
			chk("conv", cv[i], n_conv);
		end
		rchk("trim kept", IDX_TRIM, 32'h7F);
		wr(IDX_CORE_CTRL, 8'h30);
		core.sleep_op();
		ftrim <= 8'h6C;
		fuse <= 1'b0;
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		chk("reset wake", 32'h1F, {26'h0, gates});
		hresetn <= 1'b1;
		@(posedge hclk);
		rchk("trim reload", IDX_TRIM, 32'h6C);
		rchk("fuse off", IDX_PRESCALE, 32'h00);
		rchk("ctrl", IDX_CORE_CTRL, 32'h00);
		wrap_up();
	end
endmodule
